/* design/uvotp_top.sv */
// module: rail 1 under-voltage and over-temperature protection with its setup registers
`timescale 1ns/1ps
module uvotp_top
  import uvotp_pkg::*;
#(
  parameter int UV_STEP_CYC  = UV_STEP_CYCLES,
  parameter int RESTART_CYC  = RESTART_CYCLES
)
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // command register port
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_wr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_rd,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_rvalid,
  // sense inputs
  input  wire logic        uv_below_pin,
  input  wire logic        fb_below_window_pin,
  input  wire logic [7:0]  temperature_sense_input,
  input  wire logic        rail_enable_pin,
  input  wire logic        on_command,
  // rail control and status
  output logic             rail1_on,
  output logic             rail2_on,
  output logic             below_target_window_active,
  output logic             uv_fault_latched,
  output logic             ot_fault_active
);

  if (UV_STEP_CYC < 1 || RESTART_CYC < 1) begin : g_bad_param
    $error("uvotp_top: cycle counts must be at least 1");
  end

  localparam int RW = $clog2(RESTART_CYC + 1);

  // ==========================================================================
  // state
  uvotp_uv_setup_t  uv_setup_q;
  uvotp_ot_setup_t  ot_setup_q;
  uvotp_uv_state_t  uv_state_q;
  uvotp_uv_state_t  uv_state_d;
  uvotp_ot_state_t  ot_state_q;
  uvotp_ot_state_t  ot_state_d;
  logic [RW-1:0]    wait_q;
  logic [2:0]       retries_q;
  logic [1:0]       uv_sync_q;
  logic [1:0]       fb_sync_q;
  logic [1:0]       en_sync_q;
  logic             en_prev_q;
  logic             uv_fault_evt;

  // ==========================================================================
  // synchronised pins
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      uv_sync_q <= 2'h0;
      fb_sync_q <= 2'h0;
      en_sync_q <= 2'h0;
      en_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      uv_sync_q <= {uv_sync_q[0], uv_below_pin};
      fb_sync_q <= {fb_sync_q[0], fb_below_window_pin};
      en_sync_q <= {en_sync_q[0], rail_enable_pin};
      en_prev_q <= en_sync_q[1];
    end
  end

  wire logic uv_below  = uv_sync_q[1];
  wire logic fb_below  = fb_sync_q[1];
  wire logic en_level  = en_sync_q[1];
  wire logic en_rise   = en_level && !en_prev_q;
  wire logic restart_evt = en_rise || on_command;

  // ==========================================================================
  // register access
  wire logic wr_uv = cmd_wr && (cmd_code == UV_SETUP_CODE);
  wire logic wr_ot = cmd_wr && (cmd_code == OT_SETUP_CODE);
  wire logic [15:0] rd_mux =
    (cmd_code == UV_SETUP_CODE) ? {7'h00, uv_setup_q} :
    (cmd_code == OT_SETUP_CODE) ? ot_setup_q : 16'h0000;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      uv_setup_q <= UV_SETUP_RST;
      ot_setup_q <= OT_SETUP_RST;
      cmd_rdata  <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_uv)
        uv_setup_q <= cmd_wdata[UV_USED_BITS-1:0];
      if (wr_ot)
        ot_setup_q <= cmd_wdata;
      cmd_rvalid <= cmd_rd;
      if (cmd_rd)
        cmd_rdata <= rd_mux;
    end
  end

  // ==========================================================================
  // under-voltage filter
  uvotp_filter #(
    .STEP_CYCLES (UV_STEP_CYC)
  ) u_filter (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .ce           (ce),
    .below        (uv_below && uv_state_q == UV_RUN),
    .filter_steps (uv_setup_q.filter_steps),
    .fault_pulse  (uv_fault_evt)
  );

  // ==========================================================================
  // under-voltage action
  wire logic wait_done = (wait_q == RW'(RESTART_CYC - 1));
  wire logic act_stops = (uv_setup_q.action != ACT_NONE);

  always_comb
  begin
    uv_state_d = uv_state_q;
    unique case (uv_state_q)
      UV_RUN:
        if (uv_fault_evt && act_stops)
        begin
          if (uv_setup_q.action == ACT_LATCH)
            uv_state_d = UV_LATCHED;
          else if (uv_setup_q.action == ACT_RETRY && retries_q == RETRY_LIMIT)
            uv_state_d = UV_LATCHED;
          else
            uv_state_d = UV_WAIT;
        end
      UV_WAIT:
        if (restart_evt || wait_done)
          uv_state_d = UV_RUN;
      UV_LATCHED:
        if (restart_evt)
          uv_state_d = UV_RUN;
      default:
        uv_state_d = UV_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      uv_state_q <= UV_RUN;
      wait_q     <= '0;
      retries_q  <= 3'h0;
    end
    else if (ce)
    begin
      uv_state_q <= uv_state_d;
      wait_q     <= (uv_state_q == UV_WAIT && !wait_done) ? wait_q + RW'(1) : '0;
      if (restart_evt)
        retries_q <= 3'h0;
      else if (uv_fault_evt && uv_setup_q.action == ACT_RETRY && retries_q != RETRY_LIMIT)
        retries_q <= retries_q + 3'h1;
    end
  end

  // ==========================================================================
  // over-temperature
  wire logic [8:0] restart_level = {1'b0, ot_setup_q.trip_limit} - {2'b00, ot_setup_q.hysteresis};
  wire logic       ot_over  = (temperature_sense_input > ot_setup_q.trip_limit);
  wire logic       ot_cool  = !restart_level[8] &&
                              ({1'b0, temperature_sense_input} < restart_level);

  always_comb
  begin
    ot_state_d = ot_state_q;
    unique case (ot_state_q)
      OT_OK:
        if (ot_over)
          ot_state_d = OT_TRIPPED;
      OT_TRIPPED:
        if (ot_over)
          ot_state_d = OT_TRIPPED;
        else if (ot_setup_q.auto_retry && ot_cool)
          ot_state_d = OT_OK;
        else if (!ot_setup_q.auto_retry && restart_evt)
          ot_state_d = OT_OK;
    endcase
  end

  // ==========================================================================
  // outputs
  wire logic rails_allowed = en_level && ot_state_d == OT_OK;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ot_state_q                 <= OT_OK;
      rail1_on                   <= 1'b0;
      rail2_on                   <= 1'b0;
      below_target_window_active <= 1'b0;
      uv_fault_latched           <= 1'b0;
      ot_fault_active            <= 1'b0;
    end
    else if (ce)
    begin
      ot_state_q                 <= ot_state_d;
      rail1_on                   <= rails_allowed && uv_state_d == UV_RUN;
      rail2_on                   <= rails_allowed;
      below_target_window_active <= uv_setup_q.window_en && fb_below;
      uv_fault_latched           <= (uv_state_d == UV_LATCHED);
      ot_fault_active            <= (ot_state_d == OT_TRIPPED);
    end
  end

  // ==========================================================================
  // checks
  chk_reserved_read_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && cmd_rd && cmd_code == UV_SETUP_CODE) |=> (cmd_rdata[UV_RSVD_MSB:UV_RSVD_LSB] == 7'h00))
    else $error("reserved bits read nonzero");

  chk_window_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && !uv_setup_q.window_en) |=> !below_target_window_active)
    else $error("window active while disabled");

  chk_no_action_run: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && uv_state_q == UV_RUN && uv_fault_evt && uv_setup_q.action == ACT_NONE) |=> uv_state_q == UV_RUN)
    else $error("no-action mode stopped the rail");

  chk_latch_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && uv_state_q == UV_RUN && uv_fault_evt && uv_setup_q.action == ACT_LATCH)
      |=> (uv_state_q == UV_LATCHED && !rail1_on))
    else $error("latch mode did not latch off");

  chk_fault_needs_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    uv_fault_evt |-> (uv_below && $past(uv_below)) or (uv_setup_q.filter_steps == 6'h00))
    else $error("fault without sustained under-voltage");

  chk_ot_trip_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && ot_over) |=> (!rail1_on && !rail2_on && ot_fault_active))
    else $error("rails not shut off on over-temperature");

  chk_ot_retry: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && ot_state_q == OT_TRIPPED && ot_setup_q.auto_retry && !ot_over && ot_cool) |=> ot_state_q == OT_OK)
    else $error("auto retry did not restart");

  chk_ot_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && ot_state_q == OT_TRIPPED && !ot_setup_q.auto_retry && !restart_evt) |=> ot_state_q == OT_TRIPPED)
    else $error("latched over-temperature released");

  chk_hys_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && ot_state_q == OT_TRIPPED && ot_setup_q.auto_retry && !restart_level[8]
      && {1'b0, temperature_sense_input} >= restart_level) |=> ot_state_q == OT_TRIPPED)
    else $error("restart above hysteresis level");

endmodule : uvotp_top

/* design/uvotp_pkg.sv */
// package: constants and types for the rail 1 under-voltage and over-temperature protection block
//
// Operation
// - unused upper setup bits ignore writes and always read back zero
// - window enable set applies extra feedback threshold 25mV under target
// - action field: 00 none, 01 latch off, 10 hiccup, 11 retry six times
// - under-voltage fault only after output stays low for whole filter time
// - temperature above trip level shuts both rails off at once, no filtering
// - retry recovery restarts once temperature falls below trip minus hysteresis
// - latch recovery holds rails off until power cycle, enable toggle or on command
// - seven-bit hysteresis, one degree per step, below trip level for restart
package uvotp_pkg;

  // ==========================================================================
  // command codes and register layout
  localparam logic [7:0]  UV_SETUP_CODE   = 8'hd8;
  localparam logic [7:0]  OT_SETUP_CODE   = 8'hd9;
  localparam int          UV_USED_BITS    = 9;
  localparam int          UV_RSVD_LSB     = 9;
  localparam int          UV_RSVD_MSB     = 15;

  // ==========================================================================
  // setup fields
  typedef struct packed {
    logic       window_en;
    logic [1:0] action;
    logic [5:0] filter_steps;
  } uvotp_uv_setup_t;

  typedef struct packed {
    logic       auto_retry;
    logic [6:0] hysteresis;
    logic [7:0] trip_limit;
  } uvotp_ot_setup_t;

  localparam logic [8:0]  UV_SETUP_RST    = 9'h000;
  localparam logic [15:0] OT_SETUP_RST    = 16'h9e82;

  // ==========================================================================
  // action encodings
  localparam logic [1:0]  ACT_NONE        = 2'h0;
  localparam logic [1:0]  ACT_LATCH       = 2'h1;
  localparam logic [1:0]  ACT_HICCUP      = 2'h2;
  localparam logic [1:0]  ACT_RETRY       = 2'h3;
  localparam logic [2:0]  RETRY_LIMIT     = 3'h6;

  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          UV_STEP_US      = 20;
  localparam int          UV_STEP_CYCLES  = (UV_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam int          RESTART_US      = 1000;
  localparam int          RESTART_CYCLES  = (RESTART_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // rail control states
  typedef enum logic [1:0] {
    UV_RUN,
    UV_WAIT,
    UV_LATCHED
  } uvotp_uv_state_t;

  typedef enum logic {
    OT_OK,
    OT_TRIPPED
  } uvotp_ot_state_t;

endpackage : uvotp_pkg

/* design/uvotp_filter.sv */
// module: under-voltage filter timer, fires once per uninterrupted low stretch
`timescale 1ns/1ps
module uvotp_filter
  import uvotp_pkg::*;
#(
  parameter int STEP_CYCLES = UV_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  // condition and setting
  input  wire logic       below,
  input  wire logic [5:0] filter_steps,
  // result
  output logic            fault_pulse
);

  localparam int CW = $clog2(STEP_CYCLES + 1);

  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("uvotp_filter: STEP_CYCLES must be at least 1");
  end

  logic [CW-1:0] cyc_q;
  logic [5:0]    step_q;
  logic          fired_q;

  // ==========================================================================
  // decode
  wire logic expired  = (step_q == filter_steps);
  wire logic step_end = (cyc_q == CW'(STEP_CYCLES - 1));
  assign fault_pulse  = ce && below && !fired_q && expired;

  // ==========================================================================
  // counters
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cyc_q   <= '0;
      step_q  <= '0;
      fired_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!below)
      begin
        cyc_q   <= '0;
        step_q  <= '0;
        fired_q <= 1'b0;
      end
      else if (expired)
      begin
        fired_q <= 1'b1;
      end
      else if (step_end)
      begin
        cyc_q  <= '0;
        step_q <= step_q + 6'h01;
      end
      else
      begin
        cyc_q <= cyc_q + CW'(1);
      end
    end
  end

  // ==========================================================================
  // checks
  chk_filter_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce && !below) |=> (step_q == 6'h00 && cyc_q == '0))
    else $error("filter count not cleared after recovery");

endmodule : uvotp_filter

/* verification/uvotp_host_model.sv */
// host model: drives the command register port of the protection block
`timescale 1ns/1ps
module uvotp_host_model
(
  // clock
  input  wire logic        sys_clk,
  // command port
  output logic [7:0]       cmd_code,
  output logic             cmd_wr,
  output logic [15:0]      cmd_wdata,
  output logic             cmd_rd,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_rvalid
);
  // ==========================================================================
  // idle levels
  initial
  begin
    cmd_code  = 8'h00;
    cmd_wr    = 1'b0;
    cmd_wdata = 16'h0000;
    cmd_rd    = 1'b0;
  end

  // ==========================================================================
  // one write, taken at the next edge; released lines show inverted data, then one idle edge
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cmd_code  = c;
    cmd_wdata = d;
    cmd_wr    = 1'b1;
    @(posedge sys_clk);
    #2;
    cmd_wr    = 1'b0;
    cmd_wdata = ~d;
    cmd_code  = ~c;
    @(posedge sys_clk);
    #2;
  endtask : wr

  // ==========================================================================
  // one read, answer awaited for a bounded number of cycles
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    cmd_code = c;
    cmd_rd   = 1'b1;
    @(posedge sys_clk);
    #2;
    cmd_rd   = 1'b0;
    cmd_code = ~c;
    for (n = 0; n < 4 && cmd_rvalid !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      #2;
    end
    d = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hxxxx;
    @(posedge sys_clk);
    #2;
  endtask : rd
endmodule : uvotp_host_model

/* verification/test_uvotp_top.sv */
// testbench: register access and protection sequences for the protection block
`timescale 1ns/1ps
module test_uvotp_top;
  import uvotp_pkg::*;
  // ==========================================================================
  // signals
  logic        sys_clk, nrst, ce, cmd_wr, cmd_rd, cmd_rvalid;
  logic [7:0]  cmd_code, temperature_sense_input;
  logic [15:0] cmd_wdata, cmd_rdata, rv;
  logic        uv_below_pin, fb_below_window_pin, rail_enable_pin, on_command;
  logic        rail1_on, rail2_on, below_target_window_active, uv_fault_latched, ot_fault_active;
  int          err_count, total_checks, cyc;

  uvotp_top #(.UV_STEP_CYC(4), .RESTART_CYC(20)) u_uvotp_top
  (
    .sys_clk, .nrst, .ce, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rd, .cmd_rdata, .cmd_rvalid,
    .uv_below_pin, .fb_below_window_pin, .temperature_sense_input, .rail_enable_pin, .on_command,
    .rail1_on, .rail2_on, .below_target_window_active, .uv_fault_latched, .ot_fault_active
  );

  uvotp_host_model u_uvotp_host_model
  (
    .sys_clk, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rd, .cmd_rdata, .cmd_rvalid
  );

  // ==========================================================================
  // clock and hang limit
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_count++;
      $display("wrong value at %0t: cycle limit reached", $time);
      end_of_test();
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input string msg);
    u_uvotp_host_model.rd(c, rv);
    chk(rv, exp, msg);
  endtask : rd_chk

  task automatic rails(input logic r1, input logic r2, input string msg);
    chk({15'h0000, rail1_on}, {15'h0000, r1}, msg);
    chk({15'h0000, rail2_on}, {15'h0000, r2}, msg);
  endtask : rails

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // sequences
  initial
  begin
    ce = 1'b1; nrst = 1'b0; uv_below_pin = 1'b0; fb_below_window_pin = 1'b0;
    temperature_sense_input = 8'h19; rail_enable_pin = 1'b1; on_command = 1'b0;
    step(2);
    nrst = 1'b1;
    step(4);
    rails(1'b1, 1'b1, "rails after reset");
    rd_chk(8'hd8, 16'h0000, "uv setup reset");
    rd_chk(8'hd9, 16'h9e82, "ot setup reset");
    rd_chk(8'h00, 16'h0000, "unmapped read");
    u_uvotp_host_model.wr(8'hd8, 16'hffff);
    rd_chk(8'hd8, 16'h01ff, "uv upper bits");
    u_uvotp_host_model.wr(8'hd9, 16'h1234);
    rd_chk(8'hd9, 16'h1234, "ot setup rw");
    u_uvotp_host_model.wr(8'hd9, 16'h9e82);
    // below-target window
    fb_below_window_pin = 1'b1;
    u_uvotp_host_model.wr(8'hd8, 16'h0100);
    step(3);
    chk({15'h0000, below_target_window_active}, 16'h0001, "window on");
    u_uvotp_host_model.wr(8'hd8, 16'h0000);
    step(1);
    chk({15'h0000, below_target_window_active}, 16'h0000, "window off");
    // over-temperature, auto retry at 130 with 30 hysteresis
    temperature_sense_input = 8'd131;
    step(1);
    rails(1'b0, 1'b0, "ot trip");
    chk({15'h0000, ot_fault_active}, 16'h0001, "ot flag");
    temperature_sense_input = 8'd100;
    step(3);
    rails(1'b0, 1'b0, "ot within hysteresis");
    temperature_sense_input = 8'd99;
    step(2);
    rails(1'b1, 1'b1, "ot auto restart");
    // over-temperature, latch off, cleared by enable toggle
    u_uvotp_host_model.wr(8'hd9, 16'h1e82);
    temperature_sense_input = 8'd131;
    step(1);
    temperature_sense_input = 8'd50;
    step(4);
    rails(1'b0, 1'b0, "ot latched");
    rail_enable_pin = 1'b0;
    step(4);
    rail_enable_pin = 1'b1;
    step(5);
    rails(1'b1, 1'b1, "ot cleared by enable");
    // uv filter, two steps of four cycles, latch action
    u_uvotp_host_model.wr(8'hd8, 16'h0042);
    uv_below_pin = 1'b1;
    step(6);
    uv_below_pin = 1'b0;
    step(3);
    uv_below_pin = 1'b1;
    step(6);
    chk({15'h0000, uv_fault_latched}, 16'h0000, "uv interrupted stretch");
    step(8);
    chk({15'h0000, uv_fault_latched}, 16'h0001, "uv latch");
    rails(1'b0, 1'b1, "uv latch rails");
    uv_below_pin = 1'b0;
    on_command = 1'b1;
    step(1);
    on_command = 1'b0;
    step(3);
    rails(1'b1, 1'b1, "uv cleared by on");
    // action none
    u_uvotp_host_model.wr(8'hd8, 16'h0002);
    uv_below_pin = 1'b1;
    step(40);
    rails(1'b1, 1'b1, "uv no action");
    uv_below_pin = 1'b0;
    // hiccup
    u_uvotp_host_model.wr(8'hd8, 16'h0082);
    uv_below_pin = 1'b1;
    step(12);
    rails(1'b0, 1'b1, "uv hiccup off");
    uv_below_pin = 1'b0;
    step(24);
    rails(1'b1, 1'b1, "uv hiccup back");
    chk({15'h0000, uv_fault_latched}, 16'h0000, "hiccup not latched");
    // retry six times then latch
    u_uvotp_host_model.wr(8'hd8, 16'h00c2);
    uv_below_pin = 1'b1;
    step(100);
    chk({15'h0000, uv_fault_latched}, 16'h0000, "retrying");
    step(200);
    chk({15'h0000, uv_fault_latched}, 16'h0001, "retry exhausted");
    end_of_test();
  end
endmodule : test_uvotp_top
